// File: hw/npsc_power_seq.sv
`timescale 1ns/1ps
module npsc_power_seq #(
  parameter int unsigned SUPPLY_CYCLES = npsc_pkg::SUPPLY_CYC,
  parameter int unsigned OSC_CYCLES = npsc_pkg::OSC_CYC,
  parameter int unsigned INIT_CYCLES = npsc_pkg::INIT_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_idle_set, // Software writes idle request bit
  input wire logic i_powerdown_request_bit_set, // Software writes power-down request bit
  input wire logic i_ram_retain, // Keep lower RAM powered in POWER DOWN
  input wire logic i_hf_osc_sw_en, // Software enable of HF oscillator
  input wire logic i_resume_src_active, // A resume-capable unit is active
  input wire logic [npsc_pkg::RES_W-1:0] i_resume_evt, // Resume event pulses
  input wire logic i_irq, // Interrupt request
  input wire logic i_reti, // Return from interrupt
  input wire logic i_watchdog_expiry, // Watchdog elapsed
  input wire logic [npsc_pkg::WAKE_W-2:0] i_wake_evt, // Internal wake sources
  input wire logic [npsc_pkg::WAKE_W-1:0] i_ext_wake_evt, // External pins
  input wire logic i_wake_flag_rd, // Read of wake flags clears them
  output logic [1:0] o_state,
  output logic [7:0] o_config_register_zero,
  output logic [npsc_pkg::RES_W-1:0] o_resume_flags,
  output logic [npsc_pkg::WAKE_W-1:0] o_wake_flag_register,
  output logic [npsc_pkg::WAKE_W-1:0] o_external_wake_flag_register,
  output logic o_cpu_clk_en,
  output logic o_periph_supply_en,
  output logic o_low_ram_supply_en,
  output logic o_up_ram_supply_en,
  output logic o_hf_osc_en,
  output logic o_brownout_en,
  output logic o_crc_lfsr_en,
  output logic o_sfr_reinit,
  output logic o_watchdog_reinit
);
  npsc_pkg::npsc_state_t st_reg, st_next;
  logic [1:0] ph_reg, ph_next; // Wake-up phase
  logic isr_reg, isr_next; // Interrupt service in progress from IDLE
  logic [7:0] cfg_reg, cfg_next;
  logic [npsc_pkg::RES_W-1:0] ref_reg, ref_next;
  logic [npsc_pkg::WAKE_W-1:0] wf_reg, wf_next, xwf_reg, xwf_next;
  logic cpu_reg, cpu_next, sup_reg, sup_next, lram_reg, lram_next;
  logic hf_reg, hf_next, bo_reg, bo_next, crc_reg, crc_next;
  logic sfr_reg, sfr_next, wdr_reg, wdr_next;
  logic cd_wake_reg, cd_wake_next; // Carrier-detect wake latched
  logic boot_reg, boot_next; // First cycle after reset, loads the init phase
  logic tload;
  logic [npsc_pkg::CNT_W-1:0] tcount;
  logic tdone;
  logic wake_any;

  assign wake_any = (|i_wake_evt) | (|i_ext_wake_evt);

  // Phase timer for the wake-up sequence
  npsc_phase_timer #(.W(npsc_pkg::CNT_W)) u_timer (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_load(tload),
    .i_count(tcount),
    .o_done(tdone)
  );

  // Next state, flags and gating
  always_comb begin
    st_next = st_reg;
    ph_next = ph_reg;
    isr_next = isr_reg;
    cfg_next = cfg_reg;
    ref_next = ref_reg;
    wf_next = wf_reg;
    xwf_next = xwf_reg;
    cd_wake_next = cd_wake_reg;
    sfr_next = 1'b0;
    wdr_next = 1'b0;
    tload = 1'b0;
    tcount = npsc_pkg::CNT_W'(INIT_CYCLES);
    boot_next = 1'b0;
    // Reset leaves the timer empty; load the init phase once so INIT ends
    if (boot_reg) begin
      tload = 1'b1;
    end
    if (i_idle_set) begin
      cfg_next[npsc_pkg::CFG_IDLE_BIT] = 1'b1;
    end
    if (i_powerdown_request_bit_set) begin
      cfg_next[npsc_pkg::CFG_POWERDOWN_REQUEST_BIT_BIT] = 1'b1;
    end
    // Read clears flags; new events in the same cycle still set
    if (i_wake_flag_rd) begin
      wf_next = '0;
      xwf_next = '0;
    end
    if (st_reg != npsc_pkg::NPSC_POWERDOWN_REQUEST_BIT) begin
      wf_next[npsc_pkg::WAKE_W-2:0] = wf_next[npsc_pkg::WAKE_W-2:0] | i_wake_evt;
    end
    case (st_reg)
      // Running: watchdog first, then interrupt service, then power-down, then idle
      npsc_pkg::NPSC_RUN: begin
        if (i_watchdog_expiry) begin
          st_next = npsc_pkg::NPSC_INIT;
          wf_next[npsc_pkg::WF_WDOG_BIT] = 1'b1;
          sfr_next = 1'b1;
          ph_next = npsc_pkg::PH_INIT;
          tload = 1'b1;
          cfg_next = '0;
        end else if (isr_reg) begin
          // Service routine woken from IDLE; idle bit still set
          if (|i_resume_evt) begin
            ref_next = ref_reg | i_resume_evt;
            cfg_next[npsc_pkg::CFG_IDLE_BIT] = 1'b0;
            isr_next = 1'b0;
          end else if (i_reti) begin
            st_next = npsc_pkg::NPSC_IDLE;
            wdr_next = 1'b1;
            isr_next = 1'b0;
          end
        end else if (cfg_reg[npsc_pkg::CFG_POWERDOWN_REQUEST_BIT_BIT]) begin
          st_next = npsc_pkg::NPSC_POWERDOWN_REQUEST_BIT;
          wf_next = '0;
          xwf_next = '0;
          cfg_next[npsc_pkg::CFG_POWERDOWN_REQUEST_BIT_BIT] = 1'b0;
        end else if (cfg_reg[npsc_pkg::CFG_IDLE_BIT]) begin
          if (i_resume_src_active) begin
            st_next = npsc_pkg::NPSC_IDLE;
            wdr_next = 1'b1;
            isr_next = 1'b0;
          end else begin
            cfg_next[npsc_pkg::CFG_IDLE_BIT] = 1'b0;
          end
        end
      end
      // Idle: watchdog first, then resume, then interrupt handling
      npsc_pkg::NPSC_IDLE: begin
        if (i_watchdog_expiry) begin
          st_next = npsc_pkg::NPSC_INIT;
          wf_next[npsc_pkg::WF_WDOG_BIT] = 1'b1;
          sfr_next = 1'b1;
          ph_next = npsc_pkg::PH_INIT;
          tload = 1'b1;
          cfg_next = '0;
        end else if (|i_resume_evt) begin
          st_next = npsc_pkg::NPSC_RUN;
          ref_next = ref_reg | i_resume_evt;
          cfg_next[npsc_pkg::CFG_IDLE_BIT] = 1'b0;
          isr_next = 1'b0;
        end else if (i_irq) begin
          // Interrupt runs the CPU; return from it re-enters IDLE
          st_next = npsc_pkg::NPSC_RUN;
          isr_next = 1'b1;
        end
      end
      // Power down: wait for a wake-up event
      npsc_pkg::NPSC_POWERDOWN_REQUEST_BIT: begin
        if (wake_any) begin
          st_next = npsc_pkg::NPSC_INIT;
          wf_next[npsc_pkg::WAKE_W-2:0] = i_wake_evt;
          xwf_next = i_ext_wake_evt;
          cd_wake_next = i_wake_evt[npsc_pkg::WF_LFCD_BIT];
          wdr_next = 1'b1;
          sfr_next = 1'b1;
          ph_next = npsc_pkg::PH_SUPPLY;
          tload = 1'b1;
          tcount = npsc_pkg::CNT_W'(SUPPLY_CYCLES);
        end
      end
      // Init: walk the wake-up phases then run
      npsc_pkg::NPSC_INIT: begin
        if (tdone) begin
          case (ph_reg)
            npsc_pkg::PH_SUPPLY: begin
              ph_next = npsc_pkg::PH_OSC;
              tload = 1'b1;
              tcount = npsc_pkg::CNT_W'(OSC_CYCLES);
            end
            npsc_pkg::PH_OSC: begin
              ph_next = npsc_pkg::PH_INIT;
              tload = 1'b1;
              tcount = npsc_pkg::CNT_W'(INIT_CYCLES);
            end
            default: begin
              st_next = npsc_pkg::NPSC_RUN;
              cd_wake_next = 1'b0;
            end
          endcase
        end
      end
      default: begin
        st_next = npsc_pkg::NPSC_INIT;
      end
    endcase
    // Block gating derived from the next state
    cpu_next = (st_next == npsc_pkg::NPSC_RUN) ||
               (st_next == npsc_pkg::NPSC_IDLE && isr_next);
    sup_next = (st_next != npsc_pkg::NPSC_POWERDOWN_REQUEST_BIT);
    lram_next = sup_next || i_ram_retain;
    bo_next = sup_next;
    crc_next = (st_next == npsc_pkg::NPSC_RUN);
    hf_next = (sup_next && i_hf_osc_sw_en) || cd_wake_next;
  end

  // State registers; power-on reset lands in INIT
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      st_reg <= npsc_pkg::NPSC_INIT;
      ph_reg <= npsc_pkg::PH_INIT;
      boot_reg <= 1'b1;
      isr_reg <= 1'b0;
      cfg_reg <= 8'h00;
      ref_reg <= '0;
      wf_reg <= '0;
      xwf_reg <= '0;
      cd_wake_reg <= 1'b0;
      cpu_reg <= 1'b0;
      sup_reg <= 1'b1;
      lram_reg <= 1'b1;
      hf_reg <= 1'b0;
      bo_reg <= 1'b1;
      crc_reg <= 1'b0;
      sfr_reg <= 1'b0;
      wdr_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      ph_reg <= ph_next;
      boot_reg <= boot_next;
      isr_reg <= isr_next;
      cfg_reg <= cfg_next;
      ref_reg <= ref_next;
      wf_reg <= wf_next;
      xwf_reg <= xwf_next;
      cd_wake_reg <= cd_wake_next;
      cpu_reg <= cpu_next;
      sup_reg <= sup_next;
      lram_reg <= lram_next;
      hf_reg <= hf_next;
      bo_reg <= bo_next;
      crc_reg <= crc_next;
      sfr_reg <= sfr_next;
      wdr_reg <= wdr_next;
    end
  end

  // Outputs straight from flip-flops
  assign o_state = st_reg;
  assign o_config_register_zero = cfg_reg;
  assign o_resume_flags = ref_reg;
  assign o_wake_flag_register = wf_reg;
  assign o_external_wake_flag_register = xwf_reg;
  assign o_cpu_clk_en = cpu_reg;
  assign o_periph_supply_en = sup_reg;
  assign o_low_ram_supply_en = lram_reg;
  assign o_up_ram_supply_en = sup_reg;
  assign o_hf_osc_en = hf_reg;
  assign o_brownout_en = bo_reg;
  assign o_crc_lfsr_en = crc_reg;
  assign o_sfr_reinit = sfr_reg;
  assign o_watchdog_reinit = wdr_reg;

  // Assertions
  AST_POWERDOWN_REQUEST_BIT_ONLY_BY_SW: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (st_reg != npsc_pkg::NPSC_POWERDOWN_REQUEST_BIT) ##1 (st_reg == npsc_pkg::NPSC_POWERDOWN_REQUEST_BIT)
      |-> $past(cfg_reg[npsc_pkg::CFG_POWERDOWN_REQUEST_BIT_BIT]))
    else $error("power down without request");
  AST_IDLE_REFUSED: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (st_reg == npsc_pkg::NPSC_RUN && cfg_reg[npsc_pkg::CFG_IDLE_BIT] && !isr_reg &&
     !cfg_reg[npsc_pkg::CFG_POWERDOWN_REQUEST_BIT_BIT] && !i_watchdog_expiry && !i_resume_src_active)
      |=> (st_reg == npsc_pkg::NPSC_RUN && !cfg_reg[npsc_pkg::CFG_IDLE_BIT]))
    else $error("idle entered without resume source");
  AST_IDLE_CPU_OFF: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (st_reg == npsc_pkg::NPSC_IDLE && !isr_reg) |-> !o_cpu_clk_en)
    else $error("cpu clock running in idle");
  AST_RESUME: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (st_reg == npsc_pkg::NPSC_IDLE && !i_watchdog_expiry && |i_resume_evt)
      |=> (st_reg == npsc_pkg::NPSC_RUN && !cfg_reg[npsc_pkg::CFG_IDLE_BIT]))
    else $error("resume not taken");
  AST_WDOG: assert property (@(posedge i_core_clk) disable iff (i_reset)
    ((st_reg == npsc_pkg::NPSC_RUN || st_reg == npsc_pkg::NPSC_IDLE) && i_watchdog_expiry)
      |=> (st_reg == npsc_pkg::NPSC_INIT && wf_reg[npsc_pkg::WF_WDOG_BIT] && o_sfr_reinit))
    else $error("watchdog restart missing");
  AST_WAKE: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (st_reg == npsc_pkg::NPSC_POWERDOWN_REQUEST_BIT && (|i_ext_wake_evt))
      |=> (st_reg == npsc_pkg::NPSC_INIT && o_watchdog_reinit && (|xwf_reg)))
    else $error("wake-up not taken");
  AST_POWERDOWN_REQUEST_BIT_CLEAR: assert property (@(posedge i_core_clk) disable iff (i_reset)
    $rose(st_reg == npsc_pkg::NPSC_POWERDOWN_REQUEST_BIT) |-> (wf_reg == '0 && xwf_reg == '0))
    else $error("wake flags not cleared");
  AST_POWERDOWN_REQUEST_BIT_SUPPLY: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (st_reg == npsc_pkg::NPSC_POWERDOWN_REQUEST_BIT) |-> (!o_periph_supply_en && !o_brownout_en &&
      !o_cpu_clk_en && o_low_ram_supply_en == $past(i_ram_retain)))
    else $error("supply left on in power down");
  AST_INIT_EXIT: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (st_reg == npsc_pkg::NPSC_INIT && ph_reg == npsc_pkg::PH_INIT && tdone)
      |=> (st_reg == npsc_pkg::NPSC_RUN))
    else $error("init did not exit to run");
  COV_IDLE: cover property (@(posedge i_core_clk) disable iff (i_reset)
    st_reg == npsc_pkg::NPSC_IDLE ##1 st_reg == npsc_pkg::NPSC_RUN);
  COV_WAKE: cover property (@(posedge i_core_clk) disable iff (i_reset)
    st_reg == npsc_pkg::NPSC_POWERDOWN_REQUEST_BIT ##1 st_reg == npsc_pkg::NPSC_INIT);
  COV_ISR: cover property (@(posedge i_core_clk) disable iff (i_reset)
    isr_reg ##1 !isr_reg && st_reg == npsc_pkg::NPSC_IDLE);
endmodule

// File: include/npsc_pkg.sv
package npsc_pkg;
  // Sequencer states, two-bit encoding exposed to software
  typedef enum logic [1:0] {
    NPSC_RUN = 2'h0,
    NPSC_IDLE = 2'h1,
    NPSC_POWERDOWN_REQUEST_BIT = 2'h2,
    NPSC_INIT = 2'h3
  } npsc_state_t;

  // Configuration register zero bit positions
  localparam int unsigned CFG_IDLE_BIT = 5;
  localparam int unsigned CFG_POWERDOWN_REQUEST_BIT_BIT = 7;

  // Clock rate in MHz
  localparam int unsigned CLK_MHZ = 200;

  // Wake-up phase durations in microseconds
  localparam int unsigned T_SUPPLY_US = 100;
  localparam int unsigned T_OSC_US = 1150;
  localparam int unsigned T_INIT_US = 160;
  localparam int unsigned T_TOTAL_US = 1410;

  // Phase lengths in clock cycles
  localparam int unsigned SUPPLY_CYC = T_SUPPLY_US * CLK_MHZ;
  localparam int unsigned OSC_CYC = T_OSC_US * CLK_MHZ;
  localparam int unsigned INIT_CYC = T_INIT_US * CLK_MHZ;

  // Counter width for the phase timer
  localparam int unsigned CNT_W = 20;

  // Wake flag and resume flag vector widths
  localparam int unsigned WAKE_W = 8;
  localparam int unsigned RES_W = 5;

  // Wake flag bit for watchdog restart
  localparam int unsigned WF_WDOG_BIT = 7;
  // Wake flag bit for LF carrier detect
  localparam int unsigned WF_LFCD_BIT = 5;

  // Phase codes of the wake-up timer
  localparam logic [1:0] PH_SUPPLY = 2'h0;
  localparam logic [1:0] PH_OSC = 2'h1;
  localparam logic [1:0] PH_INIT = 2'h2;
endpackage

// File: hw/npsc_phase_timer.sv
`timescale 1ns/1ps
// Down counter that times one phase of the wake-up sequence
module npsc_phase_timer #(
  parameter int unsigned W = 20
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_load,
  input wire logic [W-1:0] i_count,
  output logic o_done
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic done_reg;
  logic done_next;

  // Next count: load, or decrement to zero
  always_comb begin
    cnt_next = cnt_reg;
    done_next = 1'b0;
    if (i_load) begin
      cnt_next = i_count;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - W'(1);
      done_next = (cnt_reg == W'(1));
    end
  end

  // Counter registers
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      done_reg <= done_next;
    end
  end

  assign o_done = done_reg;
endmodule

// File: sim/npsc_cpu_model.sv
`timescale 1ns/1ps
// CPU core and event sources that drive the sequencer's request inputs
module npsc_cpu_model (
  input wire logic i_core_clk,
  output logic o_idle_set,
  output logic o_powerdown_request_bit_set,
  output logic o_irq,
  output logic o_reti,
  output logic o_watchdog_expiry,
  output logic [4:0] o_resume_evt,
  output logic [6:0] o_wake_evt,
  output logic [7:0] o_ext_wake_evt,
  output logic o_wake_flag_rd
);
  // All requests idle at time zero
  initial begin
    clear_all();
  end

  // Drop every request line
  task automatic clear_all();
    {o_idle_set, o_powerdown_request_bit_set, o_irq, o_reti, o_watchdog_expiry} = 5'h00;
    {o_resume_evt, o_wake_evt, o_ext_wake_evt, o_wake_flag_rd} = 21'h000000;
  endtask

  // One-cycle request: 0 idle, 1 powerdown_request_bit, 2 irq, 3 reti, 4 wdog, 5 resume, 6 wake, 7 ext, else rd
  task automatic fire(input int k, input logic [7:0] v);
    @(posedge i_core_clk);
    #1;
    case (k)
      0: o_idle_set = 1'b1;
      1: o_powerdown_request_bit_set = 1'b1;
      2: o_irq = 1'b1;
      3: o_reti = 1'b1;
      4: o_watchdog_expiry = 1'b1;
      5: o_resume_evt = v[4:0];
      6: o_wake_evt = v[6:0];
      7: o_ext_wake_evt = v;
      default: o_wake_flag_rd = 1'b1;
    endcase
    @(posedge i_core_clk);
    #1;
    clear_all();
    // Empty slot after idle request, no new request here
    if (k == 0) begin
      @(posedge i_core_clk);
      #1;
    end
  endtask
endmodule

// File: sim/test_npsc_power_seq.sv
`timescale 1ns/1ps
// Self-checking bench for the power-state sequencer
module test_npsc_power_seq;
  localparam int unsigned SC = 4; // Shortened phase length
  logic i_core_clk, i_reset, i_ram_retain, i_hf_osc_sw_en, i_resume_src_active;
  logic idle_set, powerdown_request_bit_set, irq, reti, wdog, rd;
  logic [4:0] res_evt, res_f;
  logic [6:0] wake_evt;
  logic [7:0] ext_evt, cfg, wf, xwf;
  logic [1:0] st;
  logic cpu_clk, periph, low_ram, up_ram, hf_osc, brown, crc, sfr_ri, wd_ri;
  int errors, checks, n;

  npsc_cpu_model u_npsc_cpu_model (.i_core_clk(i_core_clk), .o_idle_set(idle_set),
    .o_powerdown_request_bit_set(powerdown_request_bit_set), .o_irq(irq), .o_reti(reti), .o_watchdog_expiry(wdog),
    .o_resume_evt(res_evt), .o_wake_evt(wake_evt), .o_ext_wake_evt(ext_evt),
    .o_wake_flag_rd(rd));

  npsc_power_seq #(.SUPPLY_CYCLES(SC), .OSC_CYCLES(SC), .INIT_CYCLES(SC)) u_npsc_power_seq (
    .i_core_clk(i_core_clk), .i_reset(i_reset), .i_idle_set(idle_set),
    .i_powerdown_request_bit_set(powerdown_request_bit_set), .i_ram_retain(i_ram_retain), .i_hf_osc_sw_en(i_hf_osc_sw_en),
    .i_resume_src_active(i_resume_src_active), .i_resume_evt(res_evt), .i_irq(irq),
    .i_reti(reti), .i_watchdog_expiry(wdog), .i_wake_evt(wake_evt),
    .i_ext_wake_evt(ext_evt), .i_wake_flag_rd(rd), .o_state(st),
    .o_config_register_zero(cfg), .o_resume_flags(res_f), .o_wake_flag_register(wf),
    .o_external_wake_flag_register(xwf), .o_cpu_clk_en(cpu_clk),
    .o_periph_supply_en(periph), .o_low_ram_supply_en(low_ram),
    .o_up_ram_supply_en(up_ram), .o_hf_osc_en(hf_osc), .o_brownout_en(brown),
    .o_crc_lfsr_en(crc), .o_sfr_reinit(sfr_ri), .o_watchdog_reinit(wd_ri));

  // Clock generator, 5 ns period
  initial begin
    i_core_clk = 1'b0;
    forever #2.5 i_core_clk = ~i_core_clk;
  end

  // Compare one value and count
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Counts, verdict, end of run
  task automatic results();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Wait a bounded number of cycles for a state
  task automatic wait_st(input logic [1:0] s, input int max, output int cyc);
    cyc = 0;
    while (st !== s && cyc < max) begin
      @(posedge i_core_clk);
      #1;
      cyc++;
    end
    chk("state_reached", {6'h00, st}, {6'h00, s});
  endtask

  // Enter IDLE with a resume-capable unit active
  task automatic idle_enter();
    i_resume_src_active = 1'b1;
    u_npsc_cpu_model.fire(0, 8'h00);
    chk("idle_state", {6'h00, st}, 8'h01);
    chk("idle_cfg5", {7'h00, cfg[5]}, 8'h01);
    chk("idle_cpu_clk", {7'h00, cpu_clk}, 8'h00);
    chk("idle_periph", {7'h00, periph}, 8'h01);
    chk("idle_crc", {7'h00, crc}, 8'h00);
  endtask

  // Idle request with no resume source is dropped
  task automatic t_idle_refused();
    i_resume_src_active = 1'b0;
    u_npsc_cpu_model.fire(0, 8'h00);
    chk("refused_state", {6'h00, st}, 8'h00);
    chk("refused_cfg5", {7'h00, cfg[5]}, 8'h00);
  endtask

  // Interrupt leaves IDLE, return goes back unless a resume came in between
  task automatic t_irq();
    idle_enter();
    u_npsc_cpu_model.fire(2, 8'h00);
    chk("irq_state", {6'h00, st}, 8'h00);
    chk("irq_cpu_clk", {7'h00, cpu_clk}, 8'h01);
    u_npsc_cpu_model.fire(3, 8'h00);
    chk("reti_state", {6'h00, st}, 8'h01);
    u_npsc_cpu_model.fire(2, 8'h00);
    u_npsc_cpu_model.fire(5, 8'h01);
    u_npsc_cpu_model.fire(3, 8'h00);
    chk("reti_after_resume", {6'h00, st}, 8'h00);
  endtask

  // Every resume source returns to RUN and is recorded
  task automatic t_resume();
    for (int i = 0; i < 5; i++) begin
      idle_enter();
      u_npsc_cpu_model.fire(5, 8'h01 << i);
      chk("resume_state", {6'h00, st}, 8'h00);
      chk("resume_cfg5", {7'h00, cfg[5]}, 8'h00);
      chk("resume_flag", {7'h00, res_f[i]}, 8'h01);
    end
  endtask

  // Watchdog expiry restarts through INIT and is flagged
  task automatic t_watchdog(input logic in_idle);
    if (in_idle) begin
      idle_enter();
    end
    u_npsc_cpu_model.fire(4, 8'h00);
    chk("wdog_state", {6'h00, st}, 8'h03);
    chk("wdog_sfr_reinit", {7'h00, sfr_ri}, 8'h01);
    chk("wdog_flag", {7'h00, wf[7]}, 8'h01);
    wait_st(npsc_pkg::NPSC_RUN, 3 * SC + 20, n);
  endtask

  // Power down and wake by a given source
  task automatic t_powerdown_request_bit(input logic keep, input int k, input logic [7:0] v,
                        input logic [7:0] wf_exp, input logic [7:0] xwf_exp);
    i_ram_retain = keep;
    u_npsc_cpu_model.fire(6, 8'h01);
    u_npsc_cpu_model.fire(1, 8'h00);
    // Request bit lands first, the state moves one edge later
    @(posedge i_core_clk);
    #1;
    chk("pd_state", {6'h00, st}, 8'h02);
    chk("pd_wf_clear", wf, 8'h00);
    chk("pd_xwf_clear", xwf, 8'h00);
    chk("pd_supplies", {cpu_clk, periph, up_ram, hf_osc, brown}, 8'h00);
    chk("pd_low_ram", {7'h00, low_ram}, {7'h00, keep});
    u_npsc_cpu_model.fire(k, v);
    chk("wake_state", {6'h00, st}, 8'h03);
    chk("wake_wd_reinit", {7'h00, wd_ri}, 8'h01);
    chk("wake_wf", wf, wf_exp);
    chk("wake_xwf", xwf, xwf_exp);
    if (k == 6) begin
      chk("wake_hf_osc", {7'h00, hf_osc}, 8'h01);
    end
    wait_st(npsc_pkg::NPSC_RUN, 3 * SC + 20, n);
    chk("wake_len_ok", {7'h00, (n >= 3 * SC && n <= 3 * SC + 6)}, 8'h01);
    chk("run_brownout", {7'h00, brown}, 8'h01);
  endtask

  // Main sequence
  initial begin
    errors = 0;
    checks = 0;
    i_reset = 1'b1;
    i_ram_retain = 1'b0;
    i_hf_osc_sw_en = 1'b0;
    i_resume_src_active = 1'b0;
    repeat (2) @(posedge i_core_clk);
    #1;
    chk("reset_state", {6'h00, st}, 8'h03);
    i_reset = 1'b0;
    wait_st(npsc_pkg::NPSC_RUN, 3 * SC + 20, n);
    t_idle_refused();
    t_irq();
    t_resume();
    t_watchdog(1'b0);
    t_watchdog(1'b1);
    t_powerdown_request_bit(1'b1, 7, 8'h08, 8'h00, 8'h08);
    t_powerdown_request_bit(1'b0, 6, 8'h20, 8'h20, 8'h00);
    results();
  end

  // Watchdog against a hang
  initial begin
    #60000;
    errors++;
    results();
  end
endmodule
